/* rtl/spmb_pkg.sv */
// Constants, carriers and types shared by the slave port mailbox.
// Assumes a single 10 MHz clock domain and an active high async reset.
package spmb_pkg;

  // ----------------------------------------------------------------
  // Widths and addresses
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;                 // Byte wide port
  localparam int unsigned ADDR_W = 2;                 // Two select lines
  localparam int unsigned BOOT_AW = 16;               // Boot address width
  localparam logic [1:0] ADDR_D0 = 2'h0;              // Data register zero
  localparam logic [1:0] ADDR_D1 = 2'h1;              // Data register one
  localparam logic [1:0] ADDR_D2 = 2'h2;              // Data register two
  localparam logic [1:0] ADDR_STAT = 2'h3;            // Status register

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_IN_FULL = 0;             // Inbound full flags, bits 2:0
  localparam int unsigned ST_OUT_FULL = 4;            // Outbound full flags, bits 6:4
  localparam int unsigned ST_IN_REQ = 3;              // Master to core request pending
  localparam int unsigned ST_OUT_REQ = 7;             // Core to master request pending

  // ----------------------------------------------------------------
  // Startup select and boot constants
  // ----------------------------------------------------------------
  localparam logic [1:0] SMODE_PORT_BOOT = 2'h1;      // hi=0, lo=1
  localparam int unsigned BOOT_IO_BIT = 15;           // Address high bit picks I/O
  localparam logic [1:0] BOOT_CNT_LAST = 2'h2;        // Third byte of a triplet
  localparam logic [1:0] SYNC_SETTLE = 2'h2;          // Cycles for pins to cross the sync
  localparam logic [7:0] BYTE_ZERO = 8'h00;           // Cleared byte

  // Core side access carrier
  typedef struct packed {
    logic             wr;    // Write strobe, one cycle
    logic             rd;    // Read strobe, one cycle
    logic [1:0]       addr;  // Register select
    logic [7:0]       wdata; // Write data
  } spmb_core_req_t;

  // Boot store carrier toward memory or I/O space
  typedef struct packed {
    logic             valid; // One cycle store pulse
    logic             io;    // Store targets I/O space
    logic [14:0]      addr;  // Address within the space
    logic [7:0]       data;  // Data byte
  } spmb_boot_st_t;

  // Boot loader states
  typedef enum logic [2:0] {
    BOOT_IDLE = 3'b001,
    BOOT_LOAD = 3'b010,
    BOOT_DONE = 3'b100
  } spmb_boot_state_t;

endpackage

/* rtl/spmb_sync.sv */
// Two flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous levels; output is flop two, two cycles after the input.
`timescale 1ns/1ps
`default_nettype none
module spmb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic [W-1:0] meta;        // First stage, read only by second stage
  logic [W-1:0] next_meta;   // Next first stage
  logic [W-1:0] next_dout;   // Next second stage

  // Next values: plain shift
  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  // Registers reset to zero
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule
`default_nettype wire

/* rtl/spmb_top.sv */
// Slave port mailbox: master pins on one side, core accesses on the other,
// plus the cold boot loader fed through the same port.
// Assumes master pins are asynchronous; strobes are active low levels.
`timescale 1ns/1ps
`default_nettype none
module spmb_top (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // Master side pins
  input  wire logic [1:0]            sp_addr,
  input  wire logic                  sp_wr_n,
  input  wire logic                  sp_rd_n,
  input  wire logic [7:0]            sp_din,
  output var  logic [7:0]            sp_dout,
  output var  logic                  sp_doe_n,
  output var  logic                  sp_attn_n,
  input  wire logic                  startup_select_hi,
  input  wire logic                  startup_select_lo,
  // Core side
  input  wire spmb_pkg::spmb_core_req_t core_req,
  output var  logic [7:0]            core_rdata,
  input  wire logic                  core_irq_en,
  output var  logic                  core_irq,
  output var  logic [7:0]            status,
  output var  logic                  boot_active,
  output var  spmb_pkg::spmb_boot_st_t boot_store
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [13:0] pins_s;       // Synchronised pins
  logic [1:0]  addr_s;       // Synchronised select
  logic        wr_n_s;       // Synchronised write strobe
  logic        rd_n_s;       // Synchronised read strobe
  logic [7:0]  din_s;        // Synchronised data
  logic [1:0]  smode_s;      // Synchronised startup select

  // Strobes enter inverted so the chain's reset zero reads as idle high (no false edge)
  spmb_sync #(.W(14)) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({startup_select_hi, startup_select_lo, sp_din, ~sp_rd_n, ~sp_wr_n, sp_addr}),
    .dout  (pins_s)
  );

  assign addr_s  = pins_s[1:0];
  assign wr_n_s  = ~pins_s[2];
  assign rd_n_s  = ~pins_s[3];
  assign din_s   = pins_s[11:4];
  assign smode_s = pins_s[13:12];

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  logic wr_n_d;              // Delayed write strobe
  logic rd_n_d;              // Delayed read strobe
  logic m_wr;                // Master write completes (rising edge)
  logic m_rd;                // Master read completes (rising edge)

  // Data is taken on the strobe's trailing edge, when the bus is settled
  assign m_wr = wr_n_s & ~wr_n_d;
  assign m_rd = rd_n_s & ~rd_n_d;

  // ----------------------------------------------------------------
  // Mailbox state
  // ----------------------------------------------------------------
  logic [7:0] in_reg  [3];   // Master to core registers
  logic [7:0] out_reg [3];   // Core to master registers
  logic [2:0] in_full;       // Inbound full flags
  logic [2:0] out_full;      // Outbound full flags
  logic       attn;          // Request toward master
  logic       cirq;          // Request toward core
  logic [7:0] next_in_reg  [3];
  logic [7:0] next_out_reg [3];
  logic [2:0] next_in_full;
  logic [2:0] next_out_full;
  logic       next_attn;
  logic       next_cirq;
  logic [7:0] next_sp_dout;
  logic       next_sp_doe_n;
  logic [7:0] next_core_rdata;
  logic [7:0] stat_val;      // Live status word

  // Index decode for a data register select
  function automatic logic [2:0] spmb_dec(input logic [1:0] a);
    spmb_dec = (a == spmb_pkg::ADDR_D0) ? 3'h1 :
               (a == spmb_pkg::ADDR_D1) ? 3'h2 :
               (a == spmb_pkg::ADDR_D2) ? 3'h4 : 3'h0;
  endfunction

  // Status word, identical for both readers
  always_comb
  begin
    stat_val = spmb_pkg::BYTE_ZERO;
    stat_val[spmb_pkg::ST_IN_FULL +: 3]  = in_full;
    stat_val[spmb_pkg::ST_OUT_FULL +: 3] = out_full;
    stat_val[spmb_pkg::ST_IN_REQ]        = in_full[0];
    stat_val[spmb_pkg::ST_OUT_REQ]       = out_full[0];
  end

  // Next values of the mailbox; sets beat clears in the same cycle
  always_comb
  begin
    logic [2:0] mw;
    logic [2:0] mr;
    logic [2:0] cw;
    logic [2:0] cr;
    mw = m_wr ? spmb_dec(addr_s) : 3'h0;
    mr = m_rd ? spmb_dec(addr_s) : 3'h0;
    cw = core_req.wr ? spmb_dec(core_req.addr) : 3'h0;
    cr = core_req.rd ? spmb_dec(core_req.addr) : 3'h0;
    // During boot the master bytes feed the loader, not the mailbox
    if (boot_active)
    begin
      mw = 3'h0;
    end
    for (int i = 0; i < 3; i++)
    begin
      next_in_reg[i]  = mw[i] ? din_s : in_reg[i];
      next_out_reg[i] = cw[i] ? core_req.wdata : out_reg[i];
    end
    next_in_full  = (in_full & ~cr) | mw;
    next_out_full = (out_full & ~mr) | cw;
    // Only register zero raises a request; status writes do nothing
    next_attn = (attn & ~mr[0]) | cw[0];
    next_cirq = (cirq & ~cr[0]) | (mw[0] & core_irq_en);
    if (!core_irq_en)
    begin
      next_cirq = 1'b0;
    end
    // Master read path: outbound registers or status only
    next_sp_doe_n = rd_n_s;
    case (addr_s)
      spmb_pkg::ADDR_D0: next_sp_dout = out_reg[0];
      spmb_pkg::ADDR_D1: next_sp_dout = out_reg[1];
      spmb_pkg::ADDR_D2: next_sp_dout = out_reg[2];
      default:           next_sp_dout = stat_val;
    endcase
    // Core read path: inbound registers or status
    case (core_req.addr)
      spmb_pkg::ADDR_D0: next_core_rdata = in_reg[0];
      spmb_pkg::ADDR_D1: next_core_rdata = in_reg[1];
      spmb_pkg::ADDR_D2: next_core_rdata = in_reg[2];
      default:           next_core_rdata = stat_val;
    endcase
    if (!core_req.rd)
    begin
      next_core_rdata = core_rdata;
    end
  end

  // Mailbox registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        in_reg[i]  <= spmb_pkg::BYTE_ZERO;
        out_reg[i] <= spmb_pkg::BYTE_ZERO;
      end
      in_full    <= 3'h0;
      out_full   <= 3'h0;
      attn       <= 1'b0;
      cirq       <= 1'b0;
      wr_n_d     <= 1'b1;
      rd_n_d     <= 1'b1;
      sp_dout    <= spmb_pkg::BYTE_ZERO;
      sp_doe_n   <= 1'b1;
      sp_attn_n  <= 1'b1;
      core_irq   <= 1'b0;
      core_rdata <= spmb_pkg::BYTE_ZERO;
      status     <= spmb_pkg::BYTE_ZERO;
    end
    else
    begin
      in_reg     <= next_in_reg;
      out_reg    <= next_out_reg;
      in_full    <= next_in_full;
      out_full   <= next_out_full;
      attn       <= next_attn;
      cirq       <= next_cirq;
      wr_n_d     <= wr_n_s;
      rd_n_d     <= rd_n_s;
      sp_dout    <= next_sp_dout;
      sp_doe_n   <= next_sp_doe_n;
      sp_attn_n  <= ~next_attn;
      core_irq   <= next_cirq;
      core_rdata <= next_core_rdata;
      status     <= stat_val;
    end
  end

  // ----------------------------------------------------------------
  // Cold boot loader
  // ----------------------------------------------------------------
  spmb_pkg::spmb_boot_state_t bstate;       // Loader state
  spmb_pkg::spmb_boot_state_t next_bstate;
  logic [1:0]  bcnt;                        // Byte within triplet
  logic [1:0]  next_bcnt;
  logic [15:0] baddr;                       // Collected address, high byte first
  logic [15:0] next_baddr;
  spmb_pkg::spmb_boot_st_t next_boot_store;
  logic        next_boot_active;

  // Startup select is only trusted once both sync stages hold the pins;
  // earlier the chain still shows its reset zero, which would mean normal start.
  always_comb
  begin
    next_bstate     = bstate;
    next_bcnt       = bcnt;
    next_baddr      = baddr;
    next_boot_store = '0;
    unique case (bstate)
      spmb_pkg::BOOT_IDLE:
      begin
        // Count the settle cycles in the triplet counter, then decide
        next_bcnt = bcnt + 2'h1;
        if (bcnt == spmb_pkg::SYNC_SETTLE)
        begin
          next_bcnt   = 2'h0;
          next_bstate = (smode_s == spmb_pkg::SMODE_PORT_BOOT) ?
                        spmb_pkg::BOOT_LOAD : spmb_pkg::BOOT_DONE;
        end
      end
      spmb_pkg::BOOT_LOAD:
      begin
        if (m_wr)
        begin
          if (bcnt == spmb_pkg::BOOT_CNT_LAST)
          begin
            next_bcnt             = 2'h0;
            next_boot_store.valid = 1'b1;
            next_boot_store.io    = baddr[spmb_pkg::BOOT_IO_BIT];
            next_boot_store.addr  = baddr[14:0];
            next_boot_store.data  = din_s;
            if (baddr[spmb_pkg::BOOT_IO_BIT])
            begin
              next_bstate = spmb_pkg::BOOT_DONE;
            end
          end
          else
          begin
            next_bcnt  = bcnt + 2'h1;
            next_baddr = {baddr[7:0], din_s};
          end
        end
      end
      spmb_pkg::BOOT_DONE:
      begin
        next_bstate = spmb_pkg::BOOT_DONE;
      end
    endcase
    next_boot_active = (next_bstate != spmb_pkg::BOOT_DONE);
  end

  // Loader registers; core held in boot until the loader finishes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      bstate      <= spmb_pkg::BOOT_IDLE;
      bcnt        <= 2'h0;
      baddr       <= 16'h0000;
      boot_store  <= '0;
      boot_active <= 1'b1;
    end
    else
    begin
      bstate      <= next_bstate;
      bcnt        <= next_bcnt;
      baddr       <= next_baddr;
      boot_store  <= next_boot_store;
      boot_active <= next_boot_active;
    end
  end

endmodule
`default_nettype wire

/* sim/spmb_checker.sv */
// Concurrent checks on the ports of the slave port mailbox top.
// Assumes one clock domain; bound into every spmb_top instance.
`timescale 1ns/1ps
`default_nettype none
module spmb_checker (
  input wire logic                     mclk,
  input wire logic                     reset,
  input wire logic                     sp_wr_n,
  input wire logic                     sp_rd_n,
  input wire logic                     sp_doe_n,
  input wire logic                     sp_attn_n,
  input wire spmb_pkg::spmb_core_req_t core_req,
  input wire logic [7:0]               core_rdata,
  input wire logic                     core_irq_en,
  input wire logic                     core_irq,
  input wire logic [7:0]               status,
  input wire logic                     boot_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Helper decodes of core accesses to data register zero
  // ------------------------------------------------------------
  logic wr0;                     // Core store to register zero
  logic rd0;                     // Core load of register zero
  assign wr0 = core_req.wr && (core_req.addr == spmb_pkg::ADDR_D0);
  assign rd0 = core_req.rd && (core_req.addr == spmb_pkg::ADDR_D0);
  // Strobes idle long enough that no synced event is still in flight
  sequence wr_quiet;
    sp_wr_n[*6];
  endsequence
  sequence rd_quiet;
    sp_rd_n[*6];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  attn_set_a: assert property (wr0 |-> ##[1:2] !sp_attn_n)
    else $error("master request not raised by core store to register zero");
  attn_cause_a: assert property ($fell(sp_attn_n) |-> $past(wr0) || $past(wr0, 2))
    else $error("master request raised without a register zero store");
  attn_hold_a: assert property ((rd_quiet ##0 !sp_attn_n) |=> !sp_attn_n)
    else $error("master request dropped without a master read");
  doe_off_a: assert property (sp_rd_n[*4] |-> sp_doe_n)
    else $error("port drives data without a read strobe");
  doe_on_a: assert property ((!sp_rd_n)[*4] |-> !sp_doe_n)
    else $error("port not driving data during a read strobe");
  irq_off_a: assert property (!core_irq_en ##1 !core_irq_en |-> !core_irq)
    else $error("core interrupt while disabled");
  irq_cause_a: assert property ($rose(core_irq) |-> $past(core_irq_en) ##1 status[3])
    else $error("core interrupt without pending inbound request");
  in_clear_a: assert property ((wr_quiet ##0 rd0) |-> ##2 (!status[3] && !core_irq))
    else $error("inbound request not cleared by core read");
  rdata_hold_a: assert property (!core_req.rd |=> $stable(core_rdata))
    else $error("core read data changed without a read");
  boot_end_a: assert property (!boot_active |=> !boot_active)
    else $error("boot phase re-entered without reset");
endmodule
bind spmb_top spmb_checker spmb_checker_inst (
  .mclk(mclk), .reset(reset), .sp_wr_n(sp_wr_n), .sp_rd_n(sp_rd_n),
  .sp_doe_n(sp_doe_n), .sp_attn_n(sp_attn_n), .core_req(core_req),
  .core_rdata(core_rdata), .core_irq_en(core_irq_en), .core_irq(core_irq),
  .status(status), .boot_active(boot_active)
);
`default_nettype wire

/* sim/spmb_master_model.sv */
// External master processor on the parallel port pins.
// Assumes the bench calls one task at a time, after reset has settled.
`timescale 1ns/1ps
`default_nettype none
module spmb_master_model (
  input  wire logic       mclk,
  input  wire logic [7:0] sp_dout,
  output var  logic [1:0] sp_addr,
  output var  logic       sp_wr_n,
  output var  logic       sp_rd_n,
  output var  logic [7:0] sp_din
);
  // Idle bus: strobes high, data bus not yet meaningful
  initial
  begin
    sp_addr = 2'h0;
    sp_wr_n = 1'b1;
    sp_rd_n = 1'b1;
    sp_din  = 8'h00;
  end
  // ------------------------------------------------------------
  // Write: strobe low 3 cycles, data held 4 cycles past rising edge
  // ------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    #5 sp_addr = a;
    sp_din  = d;
    sp_wr_n = 1'b0;
    repeat (3) @(posedge mclk);
    #5 sp_wr_n = 1'b1;
    repeat (4) @(posedge mclk);
    // Released bus shows a changed pattern, never the stale byte
    #5 sp_din = ~d;
    repeat (2) @(posedge mclk);
    #5;
  endtask
  // ------------------------------------------------------------
  // Read: answer is fixed at 3 cycles; take it before raising strobe
  // ------------------------------------------------------------
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    #5 sp_addr = a;
    sp_rd_n = 1'b0;
    repeat (4) @(posedge mclk);
    #5 d = sp_dout;
    sp_rd_n = 1'b1;
    // Allow the synced completion to clear the full flag
    repeat (5) @(posedge mclk);
    #5;
  endtask
endmodule
`default_nettype wire

/* sim/slave_port_mailbox_test.sv */
// Self-checking bench for the slave port mailbox.
// Assumes the master model drives the port pins; startup pins select normal start until the boot test.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module slave_port_mailbox_test;
  logic                     mclk;          // 10 MHz clock
  logic                     reset;         // Async reset, high
  logic [1:0]               sp_addr;       // Master select
  logic                     sp_wr_n;       // Master write strobe
  logic                     sp_rd_n;       // Master read strobe
  logic [7:0]               sp_din;        // Master write data
  logic [7:0]               sp_dout;       // Port read data
  logic                     sp_doe_n;      // Port drive enable
  logic                     sp_attn_n;     // Request to master
  logic                     smode_hi;      // Startup select, tied low
  logic                     smode_lo;      // Startup select, low until the boot test
  spmb_pkg::spmb_core_req_t core_req;      // Core access
  logic [7:0]               core_rdata;    // Core read data
  logic                     core_irq_en;   // Core interrupt enable
  logic                     core_irq;      // Core interrupt
  logic [7:0]               status;        // Status copy
  logic                     boot_active;   // Boot phase flag
  spmb_pkg::spmb_boot_st_t  boot_store;    // Boot store, sampled by the store catcher
  int                       bad_count;     // Mismatches
  int                       checks_done;   // Comparisons
  logic [7:0]               d;             // Captured read byte
  spmb_pkg::spmb_boot_st_t  last_store;    // Last boot store seen
  int                       store_cnt;     // Boot stores seen
  spmb_top spmb_top_inst (.mclk(mclk), .reset(reset), .sp_addr(sp_addr), .sp_wr_n(sp_wr_n),
    .sp_rd_n(sp_rd_n), .sp_din(sp_din), .sp_dout(sp_dout), .sp_doe_n(sp_doe_n),
    .sp_attn_n(sp_attn_n), .startup_select_hi(smode_hi), .startup_select_lo(smode_lo),
    .core_req(core_req), .core_rdata(core_rdata), .core_irq_en(core_irq_en),
    .core_irq(core_irq), .status(status), .boot_active(boot_active), .boot_store(boot_store));
  spmb_master_model spmb_master_model_inst (.mclk(mclk), .sp_dout(sp_dout), .sp_addr(sp_addr),
    .sp_wr_n(sp_wr_n), .sp_rd_n(sp_rd_n), .sp_din(sp_din));
  // Clock source
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Boot store pulse lasts one cycle; catch it where it is settled
  always @(negedge mclk)
  begin
    if (boot_store.valid)
    begin
      last_store = boot_store;
      store_cnt++;
    end
  end
  // Verdict and end of run
  task test_done;
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Core access: one-cycle pulse, then let flags and status settle
  task automatic core_acc(input logic w, input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    #5 core_req = '{wr: w, rd: ~w, addr: a, wdata: v};
    @(posedge mclk);
    #5 core_req = '0;
    @(posedge mclk);
    #5 d = core_rdata;
    repeat (2) @(posedge mclk);
    #5;
  endtask
  // Master to core: interrupt only on register zero, status write inert
  task t_inbound;
    core_irq_en = 1'b1;
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D1, 8'hA1);
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D2, 8'hA2);
    `CHK(core_irq, 1'b0)
    spmb_master_model_inst.wr(spmb_pkg::ADDR_STAT, 8'h55);
    `CHK(status, 8'h06)
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'hA0);
    `CHK(status, 8'h0F)
    `CHK(core_irq, 1'b1)
    core_acc(1'b0, spmb_pkg::ADDR_D1, 8'h00);
    `CHK(d, 8'hA1)
    core_acc(1'b0, spmb_pkg::ADDR_D2, 8'h00);
    `CHK(d, 8'hA2)
    core_acc(1'b0, spmb_pkg::ADDR_D0, 8'h00);
    `CHK(d, 8'hA0)
    `CHK(status, 8'h00)
    `CHK(core_irq, 1'b0)
  endtask
  // Master store to register zero with the core interrupt disabled
  task t_noirq;
    core_irq_en = 1'b0;
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h5A);
    `CHK(core_irq, 1'b0)
    `CHK(status, 8'h09)
    core_acc(1'b0, spmb_pkg::ADDR_D0, 8'h00);
    `CHK(d, 8'h5A)
    `CHK(status, 8'h00)
  endtask
  // Core to master: request line, reads of the opposite register, status by master
  task t_outbound;
    core_acc(1'b1, spmb_pkg::ADDR_D1, 8'hB1);
    core_acc(1'b1, spmb_pkg::ADDR_D2, 8'hB2);
    core_acc(1'b1, spmb_pkg::ADDR_STAT, 8'hFF);
    `CHK(sp_attn_n, 1'b1)
    `CHK(status, 8'h60)
    core_acc(1'b1, spmb_pkg::ADDR_D0, 8'hB0);
    `CHK(sp_attn_n, 1'b0)
    `CHK(status, 8'hF0)
    core_acc(1'b0, spmb_pkg::ADDR_D0, 8'h00);
    `CHK(d, 8'h5A)
    spmb_master_model_inst.rd(spmb_pkg::ADDR_STAT, d);
    `CHK(d, 8'hF0)
    spmb_master_model_inst.rd(spmb_pkg::ADDR_D1, d);
    `CHK(d, 8'hB1)
    spmb_master_model_inst.rd(spmb_pkg::ADDR_D2, d);
    `CHK(d, 8'hB2)
    `CHK(sp_attn_n, 1'b0)
    spmb_master_model_inst.rd(spmb_pkg::ADDR_D0, d);
    `CHK(d, 8'hB0)
    `CHK(sp_attn_n, 1'b1)
    `CHK(status, 8'h00)
  endtask
  // Mid-run reset into port cold boot: one memory triplet, then an I/O one
  task t_boot;
    @(posedge mclk);
    #5 reset = 1'b1;
    smode_lo = 1'b1;
    repeat (5) @(posedge mclk);
    #5 reset = 1'b0;
    repeat (4) @(posedge mclk);
    #5;
    `CHK(boot_active, 1'h1)
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h12);
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h34);
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h56);
    `CHK(store_cnt, 1)
    `CHK(last_store, 25'h1123456) // memory, address 1234, data 56
    `CHK(status, 8'h00)
    `CHK(boot_active, 1'h1)
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h80);
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h01);
    spmb_master_model_inst.wr(spmb_pkg::ADDR_D0, 8'h77);
    `CHK(last_store, 25'h1800177) // I/O, address 0001, data 77
    `CHK(boot_active, 1'h0)
    `CHK(store_cnt, 2)
  endtask
  // Bounded run: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done();
  end
  // Main sequence
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    store_cnt = 0;
    last_store = '0;
    reset = 1'b1;
    smode_hi = 1'b0;
    smode_lo = 1'b0;
    core_req = '0;
    core_irq_en = 1'b0;
    repeat (5) @(posedge mclk);
    #5 reset = 1'b0;
    repeat (4) @(posedge mclk);
    #5;
    `CHK(status, 8'h00)
    `CHK(sp_attn_n, 1'b1)
    t_inbound();
    t_noirq();
    t_outbound();
    t_boot();
    test_done();
  end
endmodule
`default_nettype wire
